// ### rtl/led_current_timing_flag_regs.vh
// Register offsets, reset values, flag bits and timing figures for the LED register bank
`ifndef LED_CURRENT_TIMING_FLAG_REGS_VH
`define LED_CURRENT_TIMING_FLAG_REGS_VH

`define OFS_CH2_TORCH_LEVEL 8'h06
`define OFS_CH3_FLASH_LEVEL 8'h07
`define OFS_CH3_TORCH_LEVEL 8'h08
`define OFS_CH4_FLASH_LEVEL 8'h09
`define OFS_CH4_TORCH_LEVEL 8'h0A
`define OFS_RAMP_AND_TIMEOUT 8'h0B
`define OFS_FAULT_EVENT_FLAGS 8'h0F
`define OFS_PART_IDENTIFICATION 8'h10

`define RST_LEVEL 8'h7F
`define RST_RAMP_AND_TIMEOUT 8'h1A
`define RST_FAULT_EVENT_FLAGS 8'h00

`define FLAG_FLASH_TIMEOUT 7
`define FLAG_DROOP_TRIP 6
`define FLAG_SHORT_LO 2
`define FLAG_THERMAL 1
`define FLAG_UNDERVOLT 0

`define RAMP_MSB 7
`define RAMP_LSB 4
`define TIMEOUT_MSB 3
`define TIMEOUT_LSB 0

`define CLK_PERIOD_NS 5
`define TICK_TIME_NS 1000000
`define MS_CYCLES_DEFAULT 18'h30D40
`define TIMEOUT_STEP_LO_MS 11'h028
`define TIMEOUT_BASE_HI_MS 11'h258
`define TIMEOUT_STEP_HI_MS 11'h0C8

`endif

// ### rtl/led_current_timing_flag_regs.v
// Serial-port register bank with level codes, timing, sticky flags and flash time-out
//
// How it works
// - Second channel torch code, 8 bits, reset 0x7F, about 1.46 mA per step.
// - Third channel flash code, 8 bits, reset 0x7F; step taken as 1.46 mA.
// - Third channel torch code, 8 bits, reset 0x7F, linear current per step.
// - Fourth channel flash code, 8 bits, reset 0x7F, linear current per step.
// - Fourth channel torch code, 8 bits, reset 0x7F, linear current per step.
// - Timing bits 7:4 pick torch ramp; codes 13 to 15 all mean 2048 ms.
// - Timing bits 3:0 pick flash time-out, 40 ms steps then 200 ms steps.
// - Read-only flag register: time-out, droop, four shorts, thermal, undervoltage.
// - Read-only identification code readable at register 0x10.
`timescale 1ns/1ps
`default_nettype none
`include "led_current_timing_flag_regs.vh"

module led_current_timing_flag_regs #(
  parameter [6:0] DEV_ADDR = 7'h30,  // Serial port address
  parameter [7:0] PART_ID = 8'h5A,   // Arbitrary identification value
  parameter [17:0] MS_CYCLES = `MS_CYCLES_DEFAULT  // Clock cycles per ms
) (
  input wire clk_sys_in,                 // System clock, 200 MHz
  input wire rst_n_in,                   // Synchronous reset, active low
  input wire scl_in,                     // Serial clock line level
  input wire sda_in,                     // Serial data line level
  output reg sda_out,                    // Serial data driven value
  output reg sda_oe_out,                 // Serial data drive enable
  input wire flash_req_in,               // Flash requested, level
  input wire input_voltage_droop_monitor_in, // Droop monitor trip event
  input wire [3:0] short_fault_in,       // Channel shorts, bit 3 fourth channel
  input wire thermal_shutdown_fault_in,  // Thermal shutdown event
  input wire undervoltage_lockout_fault_in, // Undervoltage lockout event
  output reg flash_drive_out,            // Flash output allowed
  output reg [7:0] ch2_torch_level_out,  // Second channel torch code
  output reg [7:0] ch3_flash_level_out,  // Third channel flash code
  output reg [7:0] ch3_torch_level_out,  // Third channel torch code
  output reg [7:0] ch4_flash_level_out,  // Fourth channel flash code
  output reg [7:0] ch4_torch_level_out,  // Fourth channel torch code
  output reg [11:0] torch_ramp_ms_out,   // Decoded torch ramp time in ms
  output reg [7:0] fault_event_flags_out // Sticky flag register
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_PTR_ACK = 4'h4;
  localparam [3:0] ST_WR = 4'h5;
  localparam [3:0] ST_WR_ACK = 4'h6;
  localparam [3:0] ST_RD = 4'h7;
  localparam [3:0] ST_RD_ACK = 4'h8;

  reg [7:0] ramp_and_timeout_q;
  reg scl_q;
  reg sda_q;
  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sr_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg nack_q;
  reg [17:0] tick_q;
  reg [10:0] ms_q;
  reg timed_out_q;
  reg [7:0] flags_d;
  reg [7:0] rd_data;
  reg [10:0] timeout_ms;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  wire bus_evt = start_cond | stop_cond;
  wire load_rd = scl_fall & ~bus_evt &
                 (((st_q == ST_ADDR_ACK) & rw_q) | ((st_q == ST_RD_ACK) & ~nack_q));
  wire wr_strobe = scl_fall & ~bus_evt & (st_q == ST_WR) & (cnt_q == 4'h8);
  wire timeout_hit = flash_req_in & ~timed_out_q & (ms_q >= timeout_ms);

  // Read mux; unmapped offsets read as zero
  always @* begin
    case (ptr_q)
      `OFS_CH2_TORCH_LEVEL: rd_data = ch2_torch_level_out;
      `OFS_CH3_FLASH_LEVEL: rd_data = ch3_flash_level_out;
      `OFS_CH3_TORCH_LEVEL: rd_data = ch3_torch_level_out;
      `OFS_CH4_FLASH_LEVEL: rd_data = ch4_flash_level_out;
      `OFS_CH4_TORCH_LEVEL: rd_data = ch4_torch_level_out;
      `OFS_RAMP_AND_TIMEOUT: rd_data = ramp_and_timeout_q;
      `OFS_FAULT_EVENT_FLAGS: rd_data = fault_event_flags_out;
      `OFS_PART_IDENTIFICATION: rd_data = PART_ID;
      default: rd_data = 8'h00;
    endcase
  end

  // Time-out decode: two linear segments
  always @* begin
    if (ramp_and_timeout_q[`TIMEOUT_MSB:`TIMEOUT_LSB] < 4'hA) begin
      timeout_ms = `TIMEOUT_STEP_LO_MS *
                   ({7'h00, ramp_and_timeout_q[`TIMEOUT_MSB:`TIMEOUT_LSB]} + 11'h001);
    end else begin
      timeout_ms = `TIMEOUT_BASE_HI_MS + `TIMEOUT_STEP_HI_MS *
                   ({7'h00, ramp_and_timeout_q[`TIMEOUT_MSB:`TIMEOUT_LSB]} - 11'h00A);
    end
  end

  // Sticky flags; a new event in the clearing cycle survives the clear
  always @* begin
    flags_d = load_rd && (ptr_q == `OFS_FAULT_EVENT_FLAGS) ?
              8'h00 : fault_event_flags_out;
    flags_d[`FLAG_FLASH_TIMEOUT] = flags_d[`FLAG_FLASH_TIMEOUT] | timeout_hit;
    flags_d[`FLAG_DROOP_TRIP] = flags_d[`FLAG_DROOP_TRIP] | input_voltage_droop_monitor_in;
    flags_d[`FLAG_SHORT_LO+3:`FLAG_SHORT_LO] =
      flags_d[`FLAG_SHORT_LO+3:`FLAG_SHORT_LO] | short_fault_in;
    flags_d[`FLAG_THERMAL] = flags_d[`FLAG_THERMAL] | thermal_shutdown_fault_in;
    flags_d[`FLAG_UNDERVOLT] = flags_d[`FLAG_UNDERVOLT] | undervoltage_lockout_fault_in;
  end

  // Register writes, flags and ramp decode
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ch2_torch_level_out <= `RST_LEVEL;
      ch3_flash_level_out <= `RST_LEVEL;
      ch3_torch_level_out <= `RST_LEVEL;
      ch4_flash_level_out <= `RST_LEVEL;
      ch4_torch_level_out <= `RST_LEVEL;
      ramp_and_timeout_q <= `RST_RAMP_AND_TIMEOUT;
      fault_event_flags_out <= `RST_FAULT_EVENT_FLAGS;
      torch_ramp_ms_out <= 12'h000;
    end else begin
      fault_event_flags_out <= flags_d;
      if (wr_strobe) begin
        case (ptr_q)
          `OFS_CH2_TORCH_LEVEL: ch2_torch_level_out <= sr_q;
          `OFS_CH3_FLASH_LEVEL: ch3_flash_level_out <= sr_q;
          `OFS_CH3_TORCH_LEVEL: ch3_torch_level_out <= sr_q;
          `OFS_CH4_FLASH_LEVEL: ch4_flash_level_out <= sr_q;
          `OFS_CH4_TORCH_LEVEL: ch4_torch_level_out <= sr_q;
          `OFS_RAMP_AND_TIMEOUT: ramp_and_timeout_q <= sr_q;
          default: ;
        endcase
      end
      // Ramp table; top three codes saturate
      case (ramp_and_timeout_q[`RAMP_MSB:`RAMP_LSB])
        4'h0: torch_ramp_ms_out <= 12'h000;
        4'h1: torch_ramp_ms_out <= 12'h001;
        4'h2: torch_ramp_ms_out <= 12'h020;
        4'h3: torch_ramp_ms_out <= 12'h040;
        4'h4: torch_ramp_ms_out <= 12'h080;
        4'h5: torch_ramp_ms_out <= 12'h100;
        4'h6: torch_ramp_ms_out <= 12'h180;
        4'h7: torch_ramp_ms_out <= 12'h200;
        4'h8: torch_ramp_ms_out <= 12'h300;
        4'h9: torch_ramp_ms_out <= 12'h400;
        4'hA: torch_ramp_ms_out <= 12'h500;
        4'hB: torch_ramp_ms_out <= 12'h600;
        4'hC: torch_ramp_ms_out <= 12'h700;
        default: torch_ramp_ms_out <= 12'h800;
      endcase
    end
  end

  // Flash timer counts whole ms while requested; drop of the request rearms it
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tick_q <= 18'h00000;
      ms_q <= 11'h000;
      timed_out_q <= 1'b0;
      flash_drive_out <= 1'b0;
    end else if (!flash_req_in) begin
      tick_q <= 18'h00000;
      ms_q <= 11'h000;
      timed_out_q <= 1'b0;
      flash_drive_out <= 1'b0;
    end else begin
      if (tick_q == MS_CYCLES - 18'h00001) begin
        tick_q <= 18'h00000;
        if (!timed_out_q) begin
          ms_q <= ms_q + 11'h001;
        end
      end else begin
        tick_q <= tick_q + 18'h00001;
      end
      if (timeout_hit) begin
        timed_out_q <= 1'b1;
      end
      flash_drive_out <= ~timed_out_q & ~timeout_hit;
    end
  end

  // Serial port engine; line inputs taken as synchronous
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_out <= 1'b0; // Open drain: only ever pulls low
      if (start_cond) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_cond) begin
        st_q <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WR) begin
          sr_q <= {sr_q[6:0], sda_in};
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == ST_RD) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == ST_RD_ACK) begin
          nack_q <= sda_in;
        end
      end else if (scl_fall) begin
        case (st_q)
          ST_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (sr_q[7:1] == DEV_ADDR) begin
                st_q <= ST_ADDR_ACK;
                rw_q <= sr_q[0];
                sda_oe_out <= 1'b1;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= sr_q;
              st_q <= ST_PTR_ACK;
              sda_oe_out <= 1'b1;
            end
          end
          ST_WR: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= ptr_q + 8'h01;
              st_q <= ST_WR_ACK;
              sda_oe_out <= 1'b1;
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            cnt_q <= 4'h0;
            if (load_rd) begin
              // Flag clearing rides on this load, so a read always returns pre-clear flags
              tx_q <= {rd_data[6:0], 1'b0};
              sda_oe_out <= ~rd_data[7];
              ptr_q <= ptr_q + 8'h01;
              st_q <= ST_RD;
            end else if (st_q == ST_ADDR_ACK) begin
              sda_oe_out <= 1'b0;
              st_q <= ST_PTR;
            end else begin
              sda_oe_out <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            sda_oe_out <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= ST_WR;
          end
          ST_RD: begin
            if (cnt_q == 4'h8) begin
              sda_oe_out <= 1'b0;
              st_q <= ST_RD_ACK;
            end else begin
              sda_oe_out <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          ST_IDLE: st_q <= ST_IDLE;
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // led_current_timing_flag_regs

`default_nettype wire

// ### tb/led_regs_checker.sv
// Port checker for the LED register bank
`timescale 1ns/1ps
`default_nettype none
module led_regs_checker (
  input wire logic clk_sys_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic scl_in, // Bus clock
  input wire logic flash_req_in, // Request
  input wire logic input_voltage_droop_monitor_in, // Droop
  input wire logic [3:0] short_fault_in, // Shorts
  input wire logic thermal_shutdown_fault_in, // Thermal
  input wire logic undervoltage_lockout_fault_in, // Undervoltage
  input wire logic flash_drive_out, // Flash on
  input wire logic [7:0] ch2_torch_level_out, // Code
  input wire logic [7:0] ch3_flash_level_out, // Code
  input wire logic [7:0] ch3_torch_level_out, // Code
  input wire logic [7:0] ch4_flash_level_out, // Code
  input wire logic [7:0] ch4_torch_level_out, // Code
  input wire logic [11:0] torch_ramp_ms_out, // Ramp
  input wire logic [7:0] fault_event_flags_out // Flags
);
  // Events in flag bit order, all codes as one word
  wire [7:0] ev = {1'b0, input_voltage_droop_monitor_in, short_fault_in,
    thermal_shutdown_fault_in, undervoltage_lockout_fault_in};
  wire [39:0] lv = {ch2_torch_level_out, ch3_flash_level_out, ch3_torch_level_out,
    ch4_flash_level_out, ch4_torch_level_out};
  wire [7:0] fl = fault_event_flags_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Commit lands on the first clock after an SCL fall; the window also admits one clock more
  property p_on; $rose(flash_req_in) |=> flash_drive_out; endproperty
  a_on: assert property (p_on) else $error("flash not started");
  property p_off; !flash_req_in |=> !flash_drive_out; endproperty
  a_off: assert property (p_off) else $error("flash without request");
  // Flag and drive cut land on the same edge, so drive was on just before
  property p_cut; $rose(fl[7]) |-> $past(flash_drive_out) && !flash_drive_out
    ##1 !flash_drive_out; endproperty
  a_cut: assert property (p_cut) else $error("time-out not cut");
  property p_set; ev != 8'h00 |=> (fl & $past(ev)) == $past(ev); endproperty
  a_set: assert property (p_set) else $error("event not flagged");
  property p_cause; (fl & ~$past(fl) & ~$past(ev) & 8'h7F) == 8'h00; endproperty
  a_cause: assert property (p_cause) else $error("flag without event");
  property p_sticky; (~fl & $past(fl)) != 8'h00 |->
    !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)); endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_ramp; torch_ramp_ms_out inside {0, 1, 32, 64, 128, 256, 384, 512, 768,
    1024, 1280, 1536, 1792, 2048}; endproperty
  a_ramp: assert property (p_ramp) else $error("bad ramp time");
  property p_commit; $changed(lv) |->
    !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)); endproperty
  a_commit: assert property (p_commit) else $error("code moved");
  c_cut: cover property ($rose(fl[7]));
  c_clear: cover property (fl != 8'h00 ##1 fl == 8'h00);
  c_code: cover property ($changed(lv));
endmodule // led_regs_checker
bind led_current_timing_flag_regs led_regs_checker u_led_regs_checker (.clk_sys_in,
  .rst_n_in, .scl_in, .flash_req_in, .input_voltage_droop_monitor_in, .short_fault_in,
  .thermal_shutdown_fault_in, .undervoltage_lockout_fault_in, .flash_drive_out,
  .ch2_torch_level_out, .ch3_flash_level_out, .ch3_torch_level_out, .ch4_flash_level_out,
  .ch4_torch_level_out, .torch_ramp_ms_out, .fault_event_flags_out);
`default_nettype wire

// ### tb/i2c_host_model.sv
// Serial bus host model facing the register bank
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk_sys_in, // Clock
  input wire logic sda_line_in, // Data line, pulled up
  output logic scl_out, // Bus clock, high when idle
  output logic sda_low_out // High pulls data low
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Four clocks a phase; only one line moves per step so no false start
  task automatic ph(input logic c, input logic d, output logic r);
    repeat (4) @(posedge clk_sys_in);
    r = sda_line_in;
    scl_out <= c;
    sda_low_out <= d;
  endtask
  task automatic start;
    logic x;
    ph(1'b0, 1'b0, x);
    ph(1'b1, 1'b0, x);
    ph(1'b1, 1'b1, x);
    ph(1'b0, 1'b1, x);
  endtask
  task automatic stop;
    logic x;
    ph(1'b0, 1'b1, x);
    ph(1'b1, 1'b1, x);
    ph(1'b1, 1'b0, x);
  endtask
  // Eight bits then the acknowledge slot; a 1 releases the line
  task automatic xfer(input logic [8:0] v, output logic [8:0] s);
    logic x;
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, !v[i], x);
      ph(1'b1, !v[i], x);
      ph(1'b0, !v[i], s[i]);
    end
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ### tb/led_current_timing_flag_regs_bench.sv
// Self-checking bench for the LED register bank
`timescale 1ns/1ps
`default_nettype none
module led_current_timing_flag_regs_bench;
  localparam logic [17:0] MS = 18'h0000A;
  localparam logic [6:0] ADDR = 7'h30;
  localparam logic [7:0] PID = 8'hC6; // Arbitrary identity value
  localparam int RAMP [16] = '{0, 1, 32, 64, 128, 256, 384, 512, 768, 1024, 1280, 1536,
    1792, 2048, 2048, 2048};
  localparam int TOC [4] = '{0, 9, 10, 15};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic flash_req = 1'b0;
  logic [6:0] events = 7'h00;
  wire scl, host_low, sda_oe, sda_o, drive;
  wire sda = !(host_low || sda_oe);
  wire [7:0] lvl [0:4];
  wire [11:0] ramp;
  wire [7:0] flags;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 48328;
  logic [7:0] exp_q [$];
  logic [7:0] v [$];
  logic [7:0] got_v;
  event got;
  led_current_timing_flag_regs #(.DEV_ADDR(ADDR), .PART_ID(PID), .MS_CYCLES(MS))
  u_led_current_timing_flag_regs (.clk_sys_in, .rst_n_in, .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .flash_req_in(flash_req),
    .input_voltage_droop_monitor_in(events[6]), .short_fault_in(events[5:2]),
    .thermal_shutdown_fault_in(events[1]), .undervoltage_lockout_fault_in(events[0]),
    .flash_drive_out(drive), .ch2_torch_level_out(lvl[0]), .ch3_flash_level_out(lvl[1]),
    .ch3_torch_level_out(lvl[2]), .ch4_flash_level_out(lvl[3]), .ch4_torch_level_out(lvl[4]),
    .torch_ramp_ms_out(ramp), .fault_event_flags_out(flags));
  i2c_host_model u_i2c_host_model (.clk_sys_in, .sda_line_in(sda), .scl_out(scl),
    .sda_low_out(host_low));
  always #2.5 clk_sys_in = !clk_sys_in;
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cut a hung run short
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out;
    end
  end
  // Each read byte against the oldest note
  always @(got) chk("read", 12'(got_v), 12'(exp_q.pop_front()));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wb(input logic [7:0] b);
    logic [8:0] s;
    u_i2c_host_model.xfer({b, 1'b1}, s);
    chk("ack", 12'(s[0]), 12'h000);
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d [$]);
    u_i2c_host_model.start;
    wb({ADDR, 1'b0});
    wb(ofs);
    foreach (d[i]) wb(d[i]);
    u_i2c_host_model.stop;
  endtask
  // Pointer write, repeated start, then bytes until a closing refusal
  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] d [$]);
    logic [8:0] s;
    u_i2c_host_model.start;
    wb({ADDR, 1'b0});
    wb(ofs);
    u_i2c_host_model.start;
    wb({ADDR, 1'b1});
    foreach (d[i]) begin
      exp_q.push_back(d[i]);
      u_i2c_host_model.xfer({8'hFF, i == d.size() - 1}, s);
      got_v = s[8:1];
      ->got;
    end
    u_i2c_host_model.stop;
  endtask
  initial begin
    logic [7:0] b;
    logic [6:0] m;
    int n;
    int lim;
    tick(20);
    rst_n_in <= 1'b1;
    tick(2);
    reg_rd(8'h06, {8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h1A});
    reg_rd(8'h0F, {8'h00, PID});
    chk("ramp_reset", ramp, 12'h001);
    chk("sda_out", 12'(sda_o), 12'h000);
    $display("done reset_values");
    // Random codes; writes to the read-only flag and identification registers must not stick
    repeat (5) v.push_back(8'($random(seed)));
    reg_wr(8'h06, v);
    tick(2);
    foreach (v[i]) chk("level", 12'(lvl[i]), 12'(v[i]));
    reg_wr(8'h0F, {8'hFF, 8'hFF});
    reg_rd(8'h0F, {8'h00, PID, 8'h00});
    reg_rd(8'h06, v);
    $display("done level_codes");
    for (int c = 0; c < 16; c++) begin
      b = {4'(c), 4'hA};
      reg_wr(8'h0B, {b});
      tick(2);
      chk("ramp", ramp, 12'(RAMP[c]));
    end
    $display("done ramp_codes");
    // One-cycle event pulses latch, hold, and clear on read
    repeat (3) begin
      m = 7'($random(seed));
      events <= m;
      tick(1);
      events <= 7'h00;
      tick(3);
      chk("flags_set", 12'(flags), 12'(m));
      tick(30);
      chk("flags_held", 12'(flags), 12'(m));
      b = {1'b0, m};
      reg_rd(8'h0F, {b});
      tick(3);
      chk("flags_clear", 12'(flags), 12'h000);
    end
    $display("done flags");
    // Flash length at the edges of both time-out step ranges
    foreach (TOC[k]) begin
      b = {4'h1, 4'(TOC[k])};
      reg_wr(8'h0B, {b});
      lim = (TOC[k] < 10) ? 40 * (TOC[k] + 1) : 600 + 200 * (TOC[k] - 10);
      lim = lim * int'(MS);
      flash_req <= 1'b1;
      n = 0;
      tick(2);
      while (drive === 1'b1 && n < 20000) begin
        n++;
        tick(1);
      end
      chk("flash_len", 12'(n + 13 >= lim && n <= lim + 13), 12'h001);
      tick(20);
      chk("drive_off", 12'(drive), 12'h000);
      flash_req <= 1'b0;
      reg_rd(8'h0F, {8'h80});
    end
    $display("done flash_timeout");
    close_out;
  end
endmodule // led_current_timing_flag_regs_bench
`default_nettype wire
